// ---- core/rstc_map.svh ----
`ifndef RSTC_MAP_SVH
`define RSTC_MAP_SVH

// register offsets (byte addresses)
`define RSTC_OFF_CMD 8'h00
`define RSTC_OFF_STAT 8'h04
`define RSTC_OFF_MODE 8'h08

// password in the top byte of command and mode writes
`define RSTC_KEY 8'ha5
`define RSTC_KEY_MSB 31
`define RSTC_KEY_LSB 24

// command register bits
`define RSTC_CMD_CPU 0
`define RSTC_CMD_PERIPH 2
`define RSTC_CMD_PIN 3

// status register fields
`define RSTC_STAT_PIN_FALL 0
`define RSTC_STAT_BROWNOUT 1
`define RSTC_STAT_CAUSE_LSB 8
`define RSTC_STAT_LEVEL 16
`define RSTC_STAT_BUSY 17

// mode register fields
`define RSTC_MODE_PIN_EN 0
`define RSTC_MODE_PIN_IRQ 4
`define RSTC_MODE_LEN_LSB 8
`define RSTC_MODE_BOD_IRQ 16

// reset values
`define RSTC_MODE_RESET 32'h0000_0000
`define RSTC_STAT_RESET 32'h0000_0000

// reset cause codes
`define RSTC_CAUSE_POWER 3'h0
`define RSTC_CAUSE_WDOG 3'h2
`define RSTC_CAUSE_SOFT 3'h3
`define RSTC_CAUSE_USER 3'h4
`define RSTC_CAUSE_BROWN 3'h5

// slow-clock cycles of a software, watchdog or user-exit reset
`define RSTC_HOLD_SLOW_CYCLES 2'h3

`endif

// ---- core/rstc_pkg.sv ----
package rstc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SOFT,
    ST_WDOG,
    ST_USER
  } rstc_phase_type;

  typedef struct packed {
    rstc_phase_type phase;
    logic [1:0] slowCnt;
    logic cpuReset;
    logic periphReset;
    logic [16:0] pulseCnt;
    logic pinOe;
    logic pinOut;
    logic pinResetEnable;
    logic pinFallIrqEnable;
    logic brownoutIrqEnable;
    logic [3:0] pulseLengthExp;
    logic pinFallFlag;
    logic brownoutFlag;
    logic [2:0] resetCause;
    logic pinLevel;
    logic brownoutPrev;
    logic slowPrev;
    logic [31:0] regRdata;
    logic irq;
  } rstc_state_type;

endpackage : rstc_pkg

// ---- core/rstc_regs.sv ----
`timescale 1ns/100ps
`include "rstc_map.svh"

module rstc_regs
  import rstc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  // slow clock, sampled as a level
  input wire logic slowClk,
  // external reset pin, open drain
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  // other reset sources
  input wire logic watchdogFault,
  input wire logic brownoutN,
  // reset and interrupt outputs
  output logic cpuReset,
  output logic periphReset,
  output logic irq
);

  rstc_state_type s;
  rstc_state_type next_s;

  logic slowRise;
  logic pinFell;
  logic brownoutFell;
  logic keyOk;
  logic cmdWrite;
  logic anyCmd;
  logic [31:0] statusWord;
  logic [31:0] modeWord;

  // read views of the status and mode registers
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`RSTC_STAT_PIN_FALL] = s.pinFallFlag;
    statusWord[`RSTC_STAT_BROWNOUT] = s.brownoutFlag;
    statusWord[`RSTC_STAT_CAUSE_LSB +: 3] = s.resetCause;
    statusWord[`RSTC_STAT_LEVEL] = s.pinLevel;
    statusWord[`RSTC_STAT_BUSY] = (s.phase == ST_SOFT);
    modeWord = 32'h0000_0000;
    modeWord[`RSTC_MODE_PIN_EN] = s.pinResetEnable;
    modeWord[`RSTC_MODE_PIN_IRQ] = s.pinFallIrqEnable;
    modeWord[`RSTC_MODE_LEN_LSB +: 4] = s.pulseLengthExp;
    modeWord[`RSTC_MODE_BOD_IRQ] = s.brownoutIrqEnable;
  end

  // edge detection and write qualification
  always_comb begin
    slowRise = slowClk & ~s.slowPrev;
    pinFell = s.pinLevel & ~pinIn;
    brownoutFell = s.brownoutPrev & ~brownoutN;
    keyOk = (regWdata[`RSTC_KEY_MSB:`RSTC_KEY_LSB] == `RSTC_KEY);
    cmdWrite = regWrite && keyOk && (regAddr == `RSTC_OFF_CMD);
    anyCmd = regWdata[`RSTC_CMD_CPU] | regWdata[`RSTC_CMD_PERIPH] | regWdata[`RSTC_CMD_PIN];
  end

  // next state of the whole controller
  always_comb begin
    next_s = s;
    next_s.regRdata = 32'h0000_0000;
    next_s.slowPrev = slowClk;
    next_s.brownoutPrev = brownoutN;
    next_s.pinLevel = pinIn;
    next_s.pinOut = 1'b0;

    // status reads clear sticky flags; cause field is kept
    if (regRead) begin
      unique case (regAddr)
        `RSTC_OFF_STAT: begin
          next_s.regRdata = statusWord;
          next_s.pinFallFlag = 1'b0;
          next_s.brownoutFlag = 1'b0;
        end
        `RSTC_OFF_MODE: begin
          next_s.regRdata = modeWord;
        end
        default: begin
          next_s.regRdata = 32'h0000_0000;
        end
      endcase
    end

    // a new edge in the read cycle wins over the clear
    if (pinFell) begin
      next_s.pinFallFlag = 1'b1;
    end
    if (brownoutFell) begin
      next_s.brownoutFlag = 1'b1;
    end

    // keyed mode write; a bad key discards the whole word
    if (regWrite && keyOk && regAddr == `RSTC_OFF_MODE) begin
      next_s.pinResetEnable = regWdata[`RSTC_MODE_PIN_EN];
      next_s.pinFallIrqEnable = regWdata[`RSTC_MODE_PIN_IRQ];
      next_s.pulseLengthExp = regWdata[`RSTC_MODE_LEN_LSB +: 4];
      next_s.brownoutIrqEnable = regWdata[`RSTC_MODE_BOD_IRQ];
    end

    // pin pulse counts down in slow-clock cycles
    if (s.pulseCnt != 17'h0_0000 && slowRise) begin
      next_s.pulseCnt = s.pulseCnt - 17'h0_0001;
    end

    // reset sequencing; watchdog outranks software, user is lowest
    unique case (s.phase)
      ST_IDLE: begin
        if (watchdogFault) begin
          next_s.phase = ST_WDOG;
          next_s.slowCnt = 2'h0;
          next_s.cpuReset = 1'b1;
          next_s.periphReset = 1'b1;
          next_s.pulseCnt = 17'h0_0001 << (5'(s.pulseLengthExp) + 5'h01);
        end else if (cmdWrite && anyCmd) begin
          next_s.phase = ST_SOFT;
          next_s.slowCnt = 2'h0;
          next_s.cpuReset = regWdata[`RSTC_CMD_CPU];
          next_s.periphReset = regWdata[`RSTC_CMD_PERIPH];
          if (regWdata[`RSTC_CMD_PIN]) begin
            // the pin follows the programmed length
            next_s.pulseCnt = 17'h0_0001 << (5'(s.pulseLengthExp) + 5'h01);
          end
        end else if (s.pinResetEnable && !s.pinLevel && !pinIn
                     && s.pulseCnt == 17'h0_0000) begin
          // own pulse on the pin never starts a user reset; the live pin must be low too,
          // since the last sample taken while our own pulse still pulled the pin is stale
          next_s.phase = ST_USER;
          next_s.slowCnt = 2'h0;
          next_s.cpuReset = 1'b1;
          next_s.periphReset = 1'b1;
        end
      end
      ST_SOFT: begin
        // command writes are dropped here by not looking at them
        if (watchdogFault) begin
          next_s.phase = ST_WDOG;
          next_s.slowCnt = 2'h0;
          next_s.cpuReset = 1'b1;
          next_s.periphReset = 1'b1;
          next_s.pulseCnt = 17'h0_0001 << (5'(s.pulseLengthExp) + 5'h01);
        end else if (slowRise) begin
          if (s.slowCnt == `RSTC_HOLD_SLOW_CYCLES - 2'h1) begin
            next_s.phase = ST_IDLE;
            next_s.cpuReset = 1'b0;
            next_s.periphReset = 1'b0;
            if (s.cpuReset) begin
              next_s.resetCause = `RSTC_CAUSE_SOFT;
            end
          end else begin
            next_s.slowCnt = s.slowCnt + 2'h1;
          end
        end
      end
      ST_WDOG: begin
        if (slowRise) begin
          if (s.slowCnt == `RSTC_HOLD_SLOW_CYCLES - 2'h1) begin
            next_s.phase = ST_IDLE;
            next_s.cpuReset = 1'b0;
            next_s.periphReset = 1'b0;
            next_s.resetCause = `RSTC_CAUSE_WDOG;
          end else begin
            next_s.slowCnt = s.slowCnt + 2'h1;
          end
        end
      end
      ST_USER: begin
        // held while the pin is low, released after it rises
        if (!s.pinLevel) begin
          next_s.slowCnt = 2'h0;
        end else if (slowRise) begin
          if (s.slowCnt == `RSTC_HOLD_SLOW_CYCLES - 2'h1) begin
            next_s.phase = ST_IDLE;
            next_s.cpuReset = 1'b0;
            next_s.periphReset = 1'b0;
            next_s.resetCause = `RSTC_CAUSE_USER;
          end else begin
            next_s.slowCnt = s.slowCnt + 2'h1;
          end
        end
      end
    endcase

    // pin driven low while the pulse counter runs
    next_s.pinOe = (next_s.pulseCnt != 17'h0_0000);

    // interrupt falls as soon as a read clears the flags
    next_s.irq = (next_s.pinFallFlag & next_s.pinFallIrqEnable
                  & ~next_s.pinResetEnable)
               | (next_s.brownoutFlag & next_s.brownoutIrqEnable);
  end

  // single register for all state; reset cause starts as power-up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s.phase <= ST_IDLE;
      s.slowCnt <= 2'h0;
      s.cpuReset <= 1'b0;
      s.periphReset <= 1'b0;
      s.pulseCnt <= 17'h0_0000;
      s.pinOe <= 1'b0;
      s.pinOut <= 1'b0;
      s.pinResetEnable <= 1'b0;
      s.pinFallIrqEnable <= 1'b0;
      s.brownoutIrqEnable <= 1'b0;
      s.pulseLengthExp <= 4'h0;
      s.pinFallFlag <= 1'b0;
      s.brownoutFlag <= 1'b0;
      s.resetCause <= `RSTC_CAUSE_POWER;
      s.pinLevel <= 1'b1;
      s.brownoutPrev <= 1'b1;
      s.slowPrev <= 1'b0;
      s.regRdata <= 32'h0000_0000;
      s.irq <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign regRdata = s.regRdata;
  assign pinOut = s.pinOut;
  assign pinOe = s.pinOe;
  assign cpuReset = s.cpuReset;
  assign periphReset = s.periphReset;
  assign irq = s.irq;

endmodule : rstc_regs

// ---- sim/rstc_regs_props.sv ----
`timescale 1ns/100ps
module rstc_regs_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  // pin and sources
  input wire logic slowClk,
  input wire logic pinIn,
  input wire logic pinOut,
  input wire logic pinOe,
  input wire logic watchdogFault,
  input wire logic brownoutN,
  // outputs
  input wire logic cpuReset,
  input wire logic periphReset,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic slowQ;
  logic wdSeen;
  logic [2:0] nSoft;
  logic [16:0] nPin;
  logic [3:0] len;
  wire rise = slowClk && !slowQ;
  wire cmd = regWrite && regAddr == 8'h00 && regWdata[31:24] == 8'ha5;
  // idle guess from ports: no reset out and three slow rises since the last taken command
  wire idle = !cpuReset && !periphReset && nSoft >= 3'h3 && !watchdogFault;
  wire acc = cmd && idle && (regWdata[0] || regWdata[2] || regWdata[3]);
  wire quiet = idle && !pinOe && pinIn;
  // slow rises since the last command; watchdog pulses start on their own, so skip them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slowQ <= 1'b0;
      wdSeen <= 1'b0;
      nSoft <= 3'h7;
      nPin <= 17'h0;
      len <= 4'h0;
    end else begin
      slowQ <= slowClk;
      wdSeen <= watchdogFault || (wdSeen && !(acc && regWdata[3]));
      if (acc) nSoft <= 3'h0;
      else if (rise && nSoft != 3'h7) nSoft <= nSoft + 3'h1;
      if (acc && regWdata[3]) nPin <= 17'h0;
      else if (rise) nPin <= nPin + 17'h1;
      if (regWrite && regAddr == 8'h08 && regWdata[31:24] == 8'ha5) len <= regWdata[11:8];
    end
  end
  sequence s_cmd(int b);
    cmd && regWdata[b] && quiet;
  endsequence
  sequence s_stRead;
    regRead && regAddr == 8'h04;
  endsequence
  property p_badKey;
    regWrite && regAddr == 8'h00 && regWdata[31:24] != 8'ha5 && quiet
      |=> !cpuReset && !periphReset && !pinOe;
  endproperty
  a_badKey: assert property (p_badKey) else $error("unkeyed command acted");
  property p_cpuCmd;
    s_cmd(0) |=> cpuReset;
  endproperty
  a_cpuCmd: assert property (p_cpuCmd) else $error("processor reset missing");
  property p_perCmd;
    s_cmd(2) |=> periphReset;
  endproperty
  a_perCmd: assert property (p_perCmd) else $error("peripheral reset missing");
  property p_pinCmd;
    s_cmd(3) |=> pinOe && !pinOut;
  endproperty
  a_pinCmd: assert property (p_pinCmd) else $error("pin not driven low");
  property p_irqClr;
    s_stRead and (pinIn && brownoutN) |=> !irq;
  endproperty
  a_irqClr: assert property (p_irqClr) else $error("irq stays after read");
  property p_pinLvl;
    s_stRead and $stable(pinIn) |=> regRdata[16] == $past(pinIn);
  endproperty
  a_pinLvl: assert property (p_pinLvl) else $error("pin level wrong");
  property p_softLen;
    $fell(cpuReset) |-> nSoft >= 3'h3;
  endproperty
  a_softLen: assert property (p_softLen) else $error("reset too short");
  property p_pulseLen;
    $fell(pinOe) && !wdSeen |-> nPin == (17'h1 << (len + 5'h1));
  endproperty
  a_pulseLen: assert property (p_pulseLen) else $error("pin pulse length wrong");
endmodule : rstc_regs_props
bind rstc_regs rstc_regs_props u_props (.clk_sys, .rst_n, .regAddr, .regWdata, .regWrite,
  .regRead, .regRdata, .slowClk, .pinIn, .pinOut, .pinOe, .watchdogFault, .brownoutN,
  .cpuReset, .periphReset, .irq);

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic slowClk = 1'b0;
  logic pinExt = 1'b1;
  logic watchdogFault = 1'b0;
  logic brownoutN = 1'b1;
  logic [31:0] regRdata;
  logic [31:0] d;
  logic pinOut, pinOe, cpuReset, periphReset, irq;
  int n_checks = 0;
  int n_mismatch = 0;
  // open-drain wire: low while the block or the board pulls it
  wire pinIn = pinExt && !pinOe;
  always #25 clk_sys = ~clk_sys;
  rstc_regs u_dut (.clk_sys, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .slowClk, .pinIn, .pinOut, .pinOe, .watchdogFault, .brownoutN, .cpuReset,
    .periphReset, .irq);
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    v = regRdata;
  endtask : rd
  // slow clock only moves here, so no write ever meets a slow edge
  task automatic slow(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      slowClk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      slowClk <= 1'b0;
    end
    tick(3);
  endtask : slow
  task automatic t_regs;
    rd(8'h04, d);
    `CHK("status", 32'h0001_0000, d)
    rd(8'h0c, d);
    `CHK("unmapped", 32'h0, d)
    wr(8'h08, 32'ha401_0f11);
    rd(8'h08, d);
    `CHK("mode", 32'h0, d)
    wr(8'h00, 32'h5a00_000d);
    `CHK("cpu", 1'b0, cpuReset)
    wr(8'h08, 32'ha501_0f11);
    rd(8'h08, d);
    `CHK("mode", 32'h0001_0f11, d)
  endtask : t_regs
  // a second command during the first is refused
  task automatic t_soft;
    wr(8'h08, 32'ha500_0000);
    wr(8'h00, 32'ha500_0009);
    `CHK("cpu", 1'b1, cpuReset)
    `CHK("pin", 2'b10, {pinOe, pinOut})
    rd(8'h04, d);
    `CHK("busy", 1'b1, d[17])
    slow(1);
    `CHK("pin", 1'b1, pinOe)
    wr(8'h00, 32'ha500_0005);
    slow(2);
    `CHK("rst", 3'h0, {cpuReset, periphReset, pinOe})
    rd(8'h04, d);
    `CHK("status", 32'h0001_0300, d & 32'hffff_fffe)
    rd(8'h04, d);
    `CHK("status", 32'h0001_0300, d)
    wr(8'h00, 32'ha500_0004);
    `CHK("rst", 2'b01, {cpuReset, periphReset})
    slow(3);
    rd(8'h04, d);
    `CHK("status", 32'h0001_0300, d)
  endtask : t_soft
  task automatic t_user;
    wr(8'h08, 32'ha500_0010);
    @(posedge clk_sys);
    pinExt <= 1'b0;
    tick(4);
    `CHK("irq cpu", 2'b10, {irq, cpuReset})
    @(posedge clk_sys);
    pinExt <= 1'b1;
    rd(8'h04, d);
    `CHK("flag irq", 2'b10, {d[0], irq})
    wr(8'h08, 32'ha500_0011);
    @(posedge clk_sys);
    pinExt <= 1'b0;
    tick(4);
    `CHK("cpu irq", 2'b10, {cpuReset, irq})
    slow(1);
    @(posedge clk_sys);
    pinExt <= 1'b1;
    slow(3);
    `CHK("cpu", 1'b0, cpuReset)
    rd(8'h04, d);
    `CHK("cause", 3'h4, d[10:8])
  endtask : t_user
  task automatic t_bod;
    for (int e = 1; e >= 0; e--) begin
      wr(8'h08, {8'ha5, 7'h0, e[0], 16'h0});
      @(posedge clk_sys);
      brownoutN <= 1'b0;
      tick(3);
      `CHK("irq", e[0], irq)
      rd(8'h04, d);
      `CHK("flags irq", 3'h4, {d[1:0], irq})
      @(posedge clk_sys);
      brownoutN <= 1'b1;
    end
    @(posedge clk_sys);
    watchdogFault <= 1'b1;
    @(posedge clk_sys);
    watchdogFault <= 1'b0;
    tick(2);
    `CHK("cpu", 1'b1, cpuReset)
    slow(4);
    rd(8'h04, d);
    `CHK("cause", 3'h2, d[10:8])
  endtask : t_bod
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(1);
    t_regs();
    t_soft();
    t_user();
    t_bod();
    results();
  end
  // hang guard
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
endmodule : tb_top
